/* logic/ssts_pkg.sv */
// shared constants, types and helpers of the serial slave timing supervisor
// assumes a single 100 MHz clock and an APB master for the registers
package ssts_pkg;

	// ----------------------------------------------------------------
	// timing
	// ----------------------------------------------------------------
	localparam int unsigned SSTS_CLOCK_MHZ   = 100;
	localparam int unsigned SSTS_MS_TICK_US  = 1000;
	localparam int unsigned SSTS_STEP_MS     = 100;
	localparam int unsigned SSTS_BAUD_BPS    = 9600;
	localparam int unsigned SSTS_MS_CYCLES   = SSTS_MS_TICK_US * SSTS_CLOCK_MHZ;
	localparam int unsigned SSTS_STEP_CYCLES = SSTS_STEP_MS * SSTS_MS_CYCLES;
	localparam int unsigned SSTS_BIT_CYCLES  =
		(SSTS_CLOCK_MHZ * 1000000) / SSTS_BAUD_BPS;

	// ----------------------------------------------------------------
	// register map and limits
	// ----------------------------------------------------------------
	localparam logic [7:0] SSTS_CFG_OFF     = 8'h00;
	localparam logic [7:0] SSTS_TMO_OFF     = 8'h04;
	localparam logic [7:0] SSTS_STAT_OFF    = 8'h08;
	localparam logic [7:0] SSTS_IRQ_ST_OFF  = 8'h0c;
	localparam logic [7:0] SSTS_IRQ_EN_OFF  = 8'h10;
	localparam logic [7:0] SSTS_IRQ_CLR_OFF = 8'h14;
	localparam logic [7:0] SSTS_ACK_OFF     = 8'h18;
	localparam logic [7:0] SSTS_DELAY_MAX   = 8'hc8;
	localparam logic [9:0] SSTS_TMO_MAX     = 10'h3e8;
	localparam logic [4:0] SSTS_FMT_MAX     = 5'h11;
	localparam logic [7:0] SSTS_BCAST       = 8'h00;
	localparam logic [7:0] SSTS_CODE_LINK   = 8'h18;
	localparam int unsigned SSTS_NIRQ       = 4;

	// error reaction codes
	localparam logic [1:0] SSTS_REACT_COAST = 2'h0;
	localparam logic [1:0] SSTS_REACT_KEEP  = 2'h1;
	localparam logic [1:0] SSTS_REACT_COMM  = 2'h2;
	localparam logic [1:0] SSTS_REACT_ALL   = 2'h3;

	// ----------------------------------------------------------------
	// types
	// ----------------------------------------------------------------
	typedef struct packed {
		logic data7;
		logic par_en;
		logic par_odd;
		logic stop2;
	} ssts_fmt_t;

	typedef struct packed {
		logic [11:0] word;
		logic [3:0]  nbits;
	} ssts_frame_t;

	typedef struct packed {
		logic [7:0] station;
		logic       is_write;
	} ssts_req_t;

	typedef struct packed {
		logic [7:0] reply_delay_setting;
		logic [7:0] station_number;
		logic [4:0] character_format_select;
		logic       write_reply_policy;
		logic [1:0] link_error_reaction;
		logic [9:0] link_timeout_setting;
	} ssts_cfg_t;

	localparam ssts_cfg_t SSTS_CFG_RST = '{
		reply_delay_setting:     8'h05,
		station_number:          8'h01,
		character_format_select: 5'h00,
		write_reply_policy:      1'h0,
		link_error_reaction:     2'h1,
		link_timeout_setting:    10'h000
	};

	// ----------------------------------------------------------------
	// format decode and frame assembly
	// ----------------------------------------------------------------
	function automatic ssts_fmt_t ssts_fmt_decode(input logic [4:0] sel);
		int        g;
		ssts_fmt_t f;
		g         = int'(sel) % 6;
		f.data7   = (sel >= 5'h06) && (sel <= 5'h0b);
		f.par_en  = (g % 3) != 0;
		f.par_odd = (g % 3) == 1;
		f.stop2   = g >= 3;
		return f;
	endfunction

	function automatic ssts_frame_t ssts_frame_build(input ssts_fmt_t f,
		input logic [7:0] d);
		ssts_frame_t r;
		logic        par;
		r.word    = '1;
		r.word[0] = 1'b0;
		if (f.data7) begin
			r.word[7:1] = d[6:0];
			par = (^d[6:0]) ^ f.par_odd;
			if (f.par_en) r.word[8] = par;
		end else begin
			r.word[8:1] = d;
			par = (^d) ^ f.par_odd;
			if (f.par_en) r.word[9] = par;
		end
		r.nbits = 4'h1 + (f.data7 ? 4'h7 : 4'h8) + {3'h0, f.par_en}
			+ (f.stop2 ? 4'h2 : 4'h1);
		return r;
	endfunction

endpackage

/* logic/ssts_tick.sv */
// periodic tick generator, restartable
// assumes a synchronous restart request from the owner
`timescale 1ns/1ps
module ssts_tick #(
	parameter int unsigned DIV = 1000
) (
	input  wire logic i_clock,
	input  wire logic i_sys_rst,
	input  wire logic i_restart,
	output logic      o_tick
);
	localparam int unsigned W = (DIV > 1) ? $clog2(DIV) : 1;
	localparam logic [W-1:0] LAST = W'(DIV - 1);

	logic [W-1:0] cnt_r;

	always_ff @(posedge i_clock or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			cnt_r  <= '0;
			o_tick <= 1'b0;
		end else if (i_restart) begin
			cnt_r  <= '0;
			o_tick <= 1'b0;
		end else if (cnt_r == LAST) begin
			cnt_r  <= '0;
			o_tick <= 1'b1;
		end else begin
			cnt_r  <= cnt_r + 1'b1;
			o_tick <= 1'b0;
		end
	end
endmodule

/* logic/ssts_char_tx.sv */
// character serializer: shifts an assembled frame out lsb first
// assumes one bit tick per bit period, restarted at each start
`timescale 1ns/1ps
module ssts_char_tx (
	input  wire logic                 i_clock,
	input  wire logic                 i_sys_rst,
	input  wire logic                 i_start,
	input  wire ssts_pkg::ssts_frame_t i_frame,
	input  wire logic                 i_bit_tick,
	output logic                      o_txd,
	output logic                      o_busy,
	output logic                      o_done
);
	import ssts_pkg::*;

	logic [11:0] sh_r;
	logic [3:0]  left_r;

	always_ff @(posedge i_clock or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			sh_r   <= '1;
			left_r <= '0;
			o_txd  <= 1'b1;
			o_busy <= 1'b0;
			o_done <= 1'b0;
		end else begin
			o_done <= 1'b0;
			if (i_start && !o_busy) begin
				sh_r   <= i_frame.word;
				left_r <= i_frame.nbits;
				o_busy <= 1'b1;
			end else if (o_busy && i_bit_tick) begin
				if (left_r != 4'h0) begin
					o_txd  <= sh_r[0];
					sh_r   <= {1'b1, sh_r[11:1]};
					left_r <= left_r - 4'h1;
				end else begin
					o_busy <= 1'b0;
					o_done <= 1'b1;
				end
			end
		end
	end
endmodule

/* logic/ssts_top.sv */
// serial slave timing supervisor: reply pacing, link silence watch,
// error reaction and character transmit, with an apb register file
// assumes a protocol engine that reports requests and streams replies
//
// The address map and the APB register port were chosen for this implementation.
`timescale 1ns/1ps
module ssts_top #(
	parameter int unsigned MS_CYCLES   = ssts_pkg::SSTS_MS_CYCLES,
	parameter int unsigned STEP_CYCLES = ssts_pkg::SSTS_STEP_CYCLES,
	parameter int unsigned BIT_CYCLES  = ssts_pkg::SSTS_BIT_CYCLES
) (
	input  wire logic               i_clock,
	input  wire logic               i_sys_rst,
	input  wire logic               i_psel,
	input  wire logic               i_penable,
	input  wire logic               i_pwrite,
	input  wire logic [7:0]         i_paddr,
	input  wire logic [31:0]        i_pwdata,
	output logic [31:0]             o_prdata,
	output logic                    o_pready,
	output logic                    o_pslverr,
	input  wire logic               i_req_valid,
	input  wire ssts_pkg::ssts_req_t i_req,
	input  wire logic               i_proc_done,
	input  wire logic               i_rx_error,
	input  wire logic               i_comm_control,
	input  wire logic               i_tx_valid,
	input  wire logic [7:0]         i_tx_data,
	input  wire logic               i_tx_last,
	output logic                    o_tx_ready,
	output logic                    o_txd,
	output logic                    o_fault_relay,
	output logic                    o_output_stop,
	output logic                    o_ramp_stop,
	output logic [7:0]              o_fault_code,
	output logic                    o_irq
);
	import ssts_pkg::*;

	typedef enum logic [3:0] {
		ST_IDLE = 4'b0001,
		ST_WAIT = 4'b0010,
		ST_SEND = 4'b0100,
		ST_DROP = 4'b1000
	} ssts_state_t;

	ssts_cfg_t             cfg_r;
	ssts_state_t           st_r;
	logic [SSTS_NIRQ-1:0]  irq_st_r;
	logic [SSTS_NIRQ-1:0]  irq_en_r;
	logic [SSTS_NIRQ-1:0]  irq_ev;
	logic [7:0]            dly_cnt_r;
	logic [9:0]            quiet_cnt_r;
	logic                  proc_seen_r;
	logic                  timed_out_r;
	logic                  fault_r;
	logic                  ramp_r;
	logic [7:0]            code_r;
	logic                  wr;
	logic                  setup;
	logic                  accept;
	logic                  quiet_req;
	logic                  delay_met;
	logic                  release_ok;
	logic                  timeout_ev;
	logic                  err_ev;
	logic                  ack;
	logic                  ms_tick;
	logic                  step_tick;
	logic                  bit_tick;
	logic                  tx_start;
	logic                  tx_busy;
	logic                  tx_done;
	ssts_fmt_t             fmt;
	ssts_frame_t           frame;
	logic [31:0]           rd_nxt;
	logic                  err_nxt;

	// ----------------------------------------------------------------
	// apb slave
	// ----------------------------------------------------------------
	assign o_pready = 1'b1;
	assign setup    = i_psel && !i_penable;
	assign wr       = i_psel && i_penable && i_pwrite;
	assign ack      = wr && (i_paddr == SSTS_ACK_OFF);

	always_comb begin
		rd_nxt  = 32'h0000_0000;
		err_nxt = 1'b0;
		if (i_paddr == SSTS_CFG_OFF) begin
			rd_nxt = {8'h00, cfg_r.link_error_reaction,
				cfg_r.write_reply_policy, cfg_r.character_format_select,
				cfg_r.station_number, cfg_r.reply_delay_setting};
		end else if (i_paddr == SSTS_TMO_OFF) begin
			rd_nxt = {22'h0, cfg_r.link_timeout_setting};
		end else if (i_paddr == SSTS_STAT_OFF) begin
			rd_nxt = {6'h0, quiet_cnt_r, 8'h0, st_r, tx_busy,
				timed_out_r, ramp_r, fault_r};
		end else if (i_paddr == SSTS_IRQ_ST_OFF) begin
			rd_nxt = {28'h0, irq_st_r};
		end else if (i_paddr == SSTS_IRQ_EN_OFF) begin
			rd_nxt = {28'h0, irq_en_r};
		end else if (i_paddr == SSTS_IRQ_CLR_OFF ||
			i_paddr == SSTS_ACK_OFF) begin
			rd_nxt = 32'h0000_0000;
		end else begin
			err_nxt = 1'b1;
		end
	end

	// read data and error are captured in the setup cycle
	always_ff @(posedge i_clock or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			o_prdata  <= 32'h0000_0000;
			o_pslverr <= 1'b0;
		end else if (setup) begin
			o_prdata  <= i_pwrite ? 32'h0000_0000 : rd_nxt;
			o_pslverr <= err_nxt;
		end
	end

	// ----------------------------------------------------------------
	// configuration
	// ----------------------------------------------------------------
	always_ff @(posedge i_clock or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			cfg_r <= SSTS_CFG_RST;
		end else if (wr && i_paddr == SSTS_CFG_OFF) begin
			cfg_r.reply_delay_setting <= (i_pwdata[7:0] > SSTS_DELAY_MAX)
				? SSTS_DELAY_MAX : i_pwdata[7:0];
			if (i_pwdata[15:8] != SSTS_BCAST)
				cfg_r.station_number <= i_pwdata[15:8];
			if (i_pwdata[20:16] <= SSTS_FMT_MAX)
				cfg_r.character_format_select <= i_pwdata[20:16];
			cfg_r.write_reply_policy  <= i_pwdata[21];
			cfg_r.link_error_reaction <= i_pwdata[23:22];
		end else if (wr && i_paddr == SSTS_TMO_OFF) begin
			cfg_r.link_timeout_setting <= (i_pwdata[9:0] > SSTS_TMO_MAX)
				? SSTS_TMO_MAX : i_pwdata[9:0];
		end
	end

	// ----------------------------------------------------------------
	// tick sources
	// ----------------------------------------------------------------
	ssts_tick #(.DIV(MS_CYCLES)) u_ms_tick (
		.i_clock   (i_clock),
		.i_sys_rst (i_sys_rst),
		.i_restart (accept),
		.o_tick    (ms_tick)
	);

	ssts_tick #(.DIV(STEP_CYCLES)) u_step_tick (
		.i_clock   (i_clock),
		.i_sys_rst (i_sys_rst),
		.i_restart (accept),
		.o_tick    (step_tick)
	);

	ssts_tick #(.DIV(BIT_CYCLES)) u_bit_tick (
		.i_clock   (i_clock),
		.i_sys_rst (i_sys_rst),
		.i_restart (tx_start),
		.o_tick    (bit_tick)
	);

	// ----------------------------------------------------------------
	// request acceptance and reply pacing
	// ----------------------------------------------------------------
	assign accept = i_req_valid && (i_req.station == cfg_r.station_number
		|| i_req.station == SSTS_BCAST);
	assign quiet_req = (i_req.station == SSTS_BCAST)
		|| (i_req.is_write && cfg_r.write_reply_policy);
	assign delay_met  = dly_cnt_r >= cfg_r.reply_delay_setting;
	assign release_ok = delay_met && proc_seen_r;

	// delay counted in whole ms from the end of the request
	always_ff @(posedge i_clock or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			dly_cnt_r <= 8'h00;
		end else if (accept) begin
			dly_cnt_r <= 8'h00;
		end else if (ms_tick && dly_cnt_r != 8'hff) begin
			dly_cnt_r <= dly_cnt_r + 8'h01;
		end
	end

	always_ff @(posedge i_clock or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			proc_seen_r <= 1'b0;
		end else if (i_proc_done) begin
			proc_seen_r <= 1'b1;
		end else if (accept) begin
			proc_seen_r <= 1'b0;
		end
	end

	always_ff @(posedge i_clock or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			st_r <= ST_IDLE;
		end else begin
			case (st_r)
			ST_IDLE: if (accept) begin
				st_r <= quiet_req ? ST_DROP : ST_WAIT;
			end
			ST_WAIT: if (release_ok) begin
				st_r <= ST_SEND;
			end
			ST_SEND: if (tx_start && i_tx_last) begin
				st_r <= ST_IDLE;
			end
			ST_DROP: if (i_tx_valid && i_tx_last) begin
				st_r <= ST_IDLE;
			end
			default: st_r <= ST_IDLE;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// character transmit
	// ----------------------------------------------------------------
	assign fmt        = ssts_fmt_decode(cfg_r.character_format_select);
	assign frame      = ssts_frame_build(fmt, i_tx_data);
	assign tx_start   = (st_r == ST_SEND) && i_tx_valid && !tx_busy;
	assign o_tx_ready = (st_r == ST_DROP) || (st_r == ST_SEND && !tx_busy);

	ssts_char_tx u_tx (
		.i_clock    (i_clock),
		.i_sys_rst  (i_sys_rst),
		.i_start    (tx_start),
		.i_frame    (frame),
		.i_bit_tick (bit_tick),
		.o_txd      (o_txd),
		.o_busy     (tx_busy),
		.o_done     (tx_done)
	);

	// ----------------------------------------------------------------
	// link silence watch
	// ----------------------------------------------------------------
	assign timeout_ev = !timed_out_r && !accept
		&& cfg_r.link_timeout_setting != 10'h000
		&& quiet_cnt_r > cfg_r.link_timeout_setting;

	always_ff @(posedge i_clock or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			quiet_cnt_r <= 10'h000;
			timed_out_r <= 1'b0;
		end else if (accept) begin
			quiet_cnt_r <= 10'h000;
			timed_out_r <= 1'b0;
		end else begin
			if (step_tick && quiet_cnt_r != 10'h3ff)
				quiet_cnt_r <= quiet_cnt_r + 10'h001;
			if (timeout_ev)
				timed_out_r <= 1'b1;
		end
	end

	// ----------------------------------------------------------------
	// error reaction and fault outputs
	// ----------------------------------------------------------------
	assign err_ev = timeout_ev || i_rx_error;

	always_ff @(posedge i_clock or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			fault_r <= 1'b0;
			code_r  <= 8'h00;
		end else if (err_ev
			&& cfg_r.link_error_reaction == SSTS_REACT_COAST) begin
			fault_r <= 1'b1;
			code_r  <= SSTS_CODE_LINK;
		end else if (ack) begin
			fault_r <= 1'b0;
			code_r  <= 8'h00;
		end
	end

	always_ff @(posedge i_clock or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			ramp_r <= 1'b0;
		end else if (err_ev && (cfg_r.link_error_reaction == SSTS_REACT_ALL
			|| (cfg_r.link_error_reaction == SSTS_REACT_COMM
			&& i_comm_control))) begin
			ramp_r <= 1'b1;
		end else if (ack) begin
			ramp_r <= 1'b0;
		end
	end

	assign o_fault_relay = fault_r;
	assign o_output_stop = fault_r;
	assign o_fault_code  = code_r;
	assign o_ramp_stop   = ramp_r;

	// ----------------------------------------------------------------
	// interrupts
	// ----------------------------------------------------------------
	assign irq_ev = {accept && i_req.station == SSTS_BCAST, tx_done,
		i_rx_error, timeout_ev};

	// a new event wins over a clear in the same cycle
	always_ff @(posedge i_clock or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			irq_st_r <= '0;
			irq_en_r <= '0;
			o_irq    <= 1'b0;
		end else begin
			if (wr && i_paddr == SSTS_IRQ_CLR_OFF)
				irq_st_r <= (irq_st_r & ~i_pwdata[SSTS_NIRQ-1:0]) | irq_ev;
			else
				irq_st_r <= irq_st_r | irq_ev;
			if (wr && i_paddr == SSTS_IRQ_EN_OFF)
				irq_en_r <= i_pwdata[SSTS_NIRQ-1:0];
			o_irq <= |(irq_st_r & irq_en_r);
		end
	end

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge i_clock); endclocking
	default disable iff (i_sys_rst);

	a_ascii_frame: assert property (cfg_r.character_format_select == 5'h07
		|-> frame.nbits == 4'ha) else $error("ascii frame not 10 bits");
	a_rtu_frame: assert property (!fmt.data7 && (fmt.par_en ^ fmt.stop2)
		|-> frame.nbits == 4'hb) else $error("rtu frame not 11 bits");
	a_delay_range: assert property (cfg_r.reply_delay_setting
		<= SSTS_DELAY_MAX) else $error("reply delay above range");
	a_proc_release: assert property (st_r == ST_WAIT && delay_met
		&& proc_seen_r |=> st_r == ST_SEND)
		else $error("reply not released");
	a_delay_hold: assert property (st_r == ST_WAIT && !delay_met
		|=> st_r != ST_SEND) else $error("reply released early");
	a_timeout_off: assert property (cfg_r.link_timeout_setting == 10'h000
		&& !timed_out_r |=> !timed_out_r) else $error("timeout while disabled");
	a_timeout_cause: assert property ($rose(timed_out_r)
		|-> $past(quiet_cnt_r) > $past(cfg_r.link_timeout_setting))
		else $error("timeout before silence");
	a_keep_running: assert property (err_ev && !ack
		&& cfg_r.link_error_reaction == SSTS_REACT_KEEP
		|=> $stable(fault_r) && $stable(ramp_r))
		else $error("keep-running reaction acted");
	a_write_quiet: assert property (st_r == ST_IDLE && accept
		&& i_req.is_write && cfg_r.write_reply_policy |=> st_r == ST_DROP)
		else $error("write reply not suppressed");
	a_fault_out: assert property ($rose(fault_r) |-> o_output_stop
		&& o_fault_relay && o_fault_code == SSTS_CODE_LINK)
		else $error("fault outputs wrong");
	a_bcast_quiet: assert property (st_r == ST_IDLE && i_req_valid
		&& i_req.station == SSTS_BCAST |=> st_r == ST_DROP)
		else $error("broadcast answered");
	a_fmt_range: assert property (cfg_r.character_format_select
		<= SSTS_FMT_MAX) else $error("format select out of range");

	c_reply_sent: cover property (st_r == ST_SEND ##[1:300] tx_done);
	c_timeout: cover property (timeout_ev);
	c_broadcast: cover property (st_r == ST_DROP ##1 st_r == ST_IDLE);
endmodule

/* test/ssts_host_model.sv */
// partner model: host side listener that captures reply characters
// assumes the slave line idles high and one bit lasts BIT clock cycles
`timescale 1ns/1ps
module ssts_host_model #(
	parameter int BIT = 4
) (
	input  wire logic   i_clock,
	input  wire logic   i_txd,
	output logic [11:0] o_word,
	output int          o_count
);
	// ----------------------------------------------------------------
	// character capture, start bit included, lsb first
	// ----------------------------------------------------------------
	// the line is looked at on the falling edge, where it has settled
	initial begin
		o_word = '1;
		o_count = 0;
		forever begin
			@(negedge i_clock);
			if (i_txd === 1'b0) begin
				repeat (BIT / 2) @(negedge i_clock);
				for (int k = 0; k < 12; k++) begin
					o_word[k] = i_txd;
					repeat (BIT) @(negedge i_clock);
				end
				o_count = o_count + 1;
			end
		end
	end
endmodule

/* test/ssts_top_tb.sv */
// self-checking bench of the serial slave timing supervisor
// assumes short counts: 10 cycles a ms, 20 a step, 4 a bit
`timescale 1ns/1ps
module ssts_top_tb;
	import ssts_pkg::*;
	logic        clk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0;
	logic [7:0]  paddr = 0, tx_data = 0;
	logic [31:0] pwdata = 0, prdata, q;
	logic        pready, pslverr, e, req_valid = 0, proc_done = 0;
	logic        rx_error = 0, comm_ctl = 0, tx_valid = 0, tx_last = 0;
	logic        tx_ready, txd, relay, ostop, ramp, irq;
	logic [7:0]  code, b;
	logic [11:0] word;
	ssts_req_t   req = '0;
	int          n_errors = 0, n_compared = 0, cnt, c, c0, dl, pd, s;
	int          seed = 32'h00d04a5c;

	ssts_top #(.MS_CYCLES(10), .STEP_CYCLES(20), .BIT_CYCLES(4)) u_dut (
		.i_clock(clk), .i_sys_rst(rst), .i_psel(psel),
		.i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr),
		.i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready),
		.o_pslverr(pslverr), .i_req_valid(req_valid), .i_req(req),
		.i_proc_done(proc_done), .i_rx_error(rx_error),
		.i_comm_control(comm_ctl), .i_tx_valid(tx_valid),
		.i_tx_data(tx_data), .i_tx_last(tx_last), .o_tx_ready(tx_ready),
		.o_txd(txd), .o_fault_relay(relay), .o_output_stop(ostop),
		.o_ramp_stop(ramp), .o_fault_code(code), .o_irq(irq));
	ssts_host_model #(.BIT(4)) u_host (.i_clock(clk), .i_txd(txd),
		.o_word(word), .o_count(cnt));

	always #5 clk = ~clk;

	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	task automatic conclude;
		$display("compared %0d errors %0d", n_compared, n_errors);
		if (n_errors == 0 && n_compared > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	task automatic chk(input logic [31:0] g, input logic [31:0] x);
		n_compared++;
		if (g !== x) begin
			n_errors++;
			$display("FAIL %0t got %h expected %h", $time, g, x);
		end
	endtask

	task automatic apb(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		int i;
		psel <= 1;
		penable <= 0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1;
		for (i = 0; i < 20; i++) begin
			@(posedge clk);
			if (pready === 1'b1) break;
		end
		q = prdata;
		e = pslverr;
		psel <= 0;
		penable <= 0;
		@(posedge clk);
		if (i == 20) begin
			n_errors++;
			conclude();
		end
	endtask

	function automatic logic [31:0] cfg(int d, int st, int f, int p, int r);
		return {8'h00, r[1:0], p[0], f[4:0], st[7:0], d[7:0]};
	endfunction

	function automatic logic [11:0] frame(input int sl, input logic [7:0] d);
		logic [11:0] w;
		int          n;
		logic        p;
		w = '1;
		w[0] = 1'b0;
		n = (sl >= 6 && sl <= 11) ? 7 : 8;
		for (int i = 0; i < n; i++) w[1 + i] = d[i];
		p = ^(d & ((n == 7) ? 8'h7f : 8'hff));
		if (sl % 3 == 1) w[1 + n] = ~p;
		if (sl % 3 == 2) w[1 + n] = p;
		return w;
	endfunction

	// request, then offer one reply byte until taken; c counts cycles
	task automatic reply(input logic [7:0] st, input logic wr, input int p);
		req_valid <= 1;
		req <= '{station: st, is_write: wr};
		tx_valid <= 1;
		tx_data <= b;
		tx_last <= 1;
		c0 = cnt;
		for (c = 0; c < 3000; c++) begin
			@(posedge clk);
			req_valid <= 0;
			proc_done <= (c + 1 == p);
			if (tx_ready === 1'b1) break;
		end
		tx_valid <= 0;
		tx_last <= 0;
		proc_done <= 0;
		if (c == 3000) begin
			n_errors++;
			conclude();
		end
	endtask

	task automatic wait_host(output logic got);
		got = 0;
		for (int i = 0; i < 120; i++) begin
			@(posedge clk);
			if (cnt != c0) got = 1;
		end
	endtask

	// ----------------------------------------------------------------
	// main sequence
	// ----------------------------------------------------------------
	initial begin
		repeat (10) @(posedge clk);
		rst <= 0;
		@(posedge clk);
		apb(0, SSTS_CFG_OFF, 0);
		chk(q, 32'h0040_0105);
		apb(0, SSTS_TMO_OFF, 0);
		chk(q, 0);
		apb(0, 8'h40, 0);
		chk({e, q}, {1'b1, 32'h0});
		for (int k = 0; k < 7; k++) begin
			s = (k == 1) ? 7 : (k == 2) ? 17 : $unsigned($random(seed)) % 18;
			dl = (k == 0) ? 5 : $unsigned($random(seed)) % 4;
			pd = 1 + $unsigned($random(seed)) % 40;
			b = 8'($random(seed));
			if (k == 0) s = 0;
			else apb(1, SSTS_CFG_OFF, cfg(dl, 1, s, 0, 1));
			reply(1, 0, pd);
			chk(c >= dl * 10 && c >= pd, 1);
			if (pd <= dl * 10) chk(c <= dl * 10 + 4, 1);
			if (pd > dl * 10 + 4) chk(c <= pd + 4, 1);
			wait_host(e);
			chk({e, word}, {1'b1, frame(s, b)});
		end
		b = 8'ha5;
		reply(0, 0, 1);
		wait_host(e);
		chk(e, 0);
		apb(1, SSTS_CFG_OFF, cfg(0, 1, 0, 1, 1));
		reply(1, 1, 1);
		wait_host(e);
		chk(e, 0);
		apb(1, SSTS_CFG_OFF, cfg(0, 1, 0, 0, 0));
		reply(1, 1, 1);
		wait_host(e);
		chk({e, word}, {1'b1, frame(0, b)});
		apb(1, SSTS_IRQ_EN_OFF, 32'h1);
		apb(1, SSTS_TMO_OFF, 32'h1);
		repeat (150) @(posedge clk);
		chk({relay, ostop, code, irq}, {2'b11, SSTS_CODE_LINK, 1'b1});
		apb(0, SSTS_IRQ_ST_OFF, 0);
		chk(q, 32'hd);
		apb(1, SSTS_TMO_OFF, 0);
		apb(1, SSTS_ACK_OFF, 0);
		apb(1, SSTS_IRQ_CLR_OFF, 32'hf);
		repeat (200) @(posedge clk);
		chk({relay, ostop, code, irq}, 0);
		for (int r = 0; r < 8; r++) begin
			apb(1, SSTS_CFG_OFF, cfg(0, 1, 0, 0, r / 2));
			comm_ctl <= r[0];
			rx_error <= 1;
			@(posedge clk);
			rx_error <= 0;
			repeat (3) @(posedge clk);
			chk({relay, ramp}, {r / 2 == 0, r / 2 == 3 || r == 5});
			apb(1, SSTS_ACK_OFF, 0);
		end
		apb(1, SSTS_CFG_OFF, cfg(250, 0, 18, 0, 1));
		apb(0, SSTS_CFG_OFF, 0);
		chk(q, 32'h0040_01c8);
		conclude();
	end
endmodule
